// ### src/ppc_cfg.sv
/*
  polarity and commutation configuration slice of a six-channel pwm unit,
  with its ahb-lite register slave and per-channel compare outputs.
  assumes i_count and i_comm_event come from logic on i_clk; no synchroniser.
*/
`timescale 1ns/1ps
module ppc_cfg #(
  parameter int NUM_CH    = ppc_pkg::NUM_CH,
  parameter int CNT_WIDTH = ppc_pkg::CNT_WIDTH
) (
  // clock and reset
  input  wire logic                 i_clk,
  input  wire logic                 i_resetn,
  // ahb-lite slave
  input  wire logic                 i_hsel,
  input  wire logic [31:0]          i_haddr,
  input  wire logic [1:0]           i_htrans,
  input  wire logic                 i_hwrite,
  input  wire logic [2:0]           i_hsize,
  input  wire logic [31:0]          i_hwdata,
  input  wire logic                 i_hready,
  output logic      [31:0]          o_hrdata,
  output logic                      o_hreadyout,
  output logic                      o_hresp,
  // pwm core side
  input  wire logic [CNT_WIDTH-1:0] i_count,
  input  wire logic                 i_comm_event,
  // channel outputs
  output logic      [NUM_CH-1:0]    o_pwm,
  output logic      [NUM_CH-1:0]    o_override_ctl,
  output logic      [NUM_CH-1:0]    o_override_val,
  output logic      [NUM_CH-1:0]    o_mask
);
  // register state
  logic [7:0]        cfg_reg;
  logic              protect_reg;
  logic [NUM_CH-1:0] outctl_buf_reg;
  logic [NUM_CH-1:0] outval_buf_reg;
  logic [NUM_CH-1:0] mask_buf_reg;
  logic [NUM_CH-1:0] outctl_reg;
  logic [NUM_CH-1:0] outval_reg;
  logic [NUM_CH-1:0] mask_reg;
  logic [NUM_CH-1:0] pwm_reg;
  logic [NUM_CH-1:0] pwm_next;
  logic              wr_pend_reg;
  logic [7:0]        addr_reg;
  logic [31:0]       rdata_next;
  logic [NUM_CH*CNT_WIDTH-1:0] pw_all;

  // address lands in the pulse-width window; shared by write and read decode
  function automatic logic in_pw_window(input logic [7:0] a);
    return (a >= ppc_pkg::PWVAL_OFFSET) && (a < ppc_pkg::PWVAL_OFFSET + 8'(4 * NUM_CH));
  endfunction

  // address phase decode
  wire        addr_phase = i_hsel && i_hready && i_htrans[1];
  wire        wr_now     = wr_pend_reg;
  wire        buf_en     = cfg_reg[ppc_pkg::CFG_BUF_EN_BIT];
  wire [NUM_CH-1:0] wd_ch = i_hwdata[NUM_CH-1:0];
  wire        wr_cfg     = wr_now && (addr_reg == ppc_pkg::CFG_OFFSET) && !protect_reg;
  wire        wr_outctl  = wr_now && (addr_reg == ppc_pkg::OUTCTL_OFFSET);
  wire        wr_outval  = wr_now && (addr_reg == ppc_pkg::OUTVAL_OFFSET);
  wire        wr_mask    = wr_now && (addr_reg == ppc_pkg::MASK_OFFSET);
  wire        wr_prot    = wr_now && (addr_reg == ppc_pkg::PROTECT_OFFSET);
  wire        wr_pw      = wr_now && in_pw_window(addr_reg);
  wire [7:0]  pw_off     = addr_reg - ppc_pkg::PWVAL_OFFSET;
  wire [2:0]  pw_idx     = pw_off[4:2];
  // event only honoured while buffering is on
  wire        comm_take  = buf_en && i_comm_event;

  // channel polarity: only pair c low side has an invert bit here
  function automatic logic [NUM_CH-1:0] invert_mask(input logic [7:0] cfg);
    logic [NUM_CH-1:0] m;
    m = '0;
    m[ppc_pkg::C_LOW_CH] = cfg[ppc_pkg::CFG_C_LOW_INV];
    return m;
  endfunction

  // pulse-width store
  ppc_pw_mem #(
    .DEPTH (NUM_CH),
    .WIDTH (CNT_WIDTH)
  ) u_pw_mem (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_we     (wr_pw),
    .i_waddr  (pw_idx),
    .i_wdata  (i_hwdata[CNT_WIDTH-1:0]),
    .o_rdata  (pw_all)
  );

  // bus data phase tracking
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      wr_pend_reg <= 1'b0;
      addr_reg    <= 8'h00;
    end else if (i_hready) begin
      wr_pend_reg <= addr_phase && i_hwrite;
      addr_reg    <= addr_phase ? {i_haddr[7:2], 2'b00} : addr_reg;
    end
  end

  // configuration and protection
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      cfg_reg     <= ppc_pkg::CFG_RESET;
      protect_reg <= 1'b0;
    end else begin
      if (wr_cfg) begin
        cfg_reg <= {1'b0, i_hwdata[ppc_pkg::CFG_BUF_EN_BIT:ppc_pkg::CFG_C_LOW_INV], 5'h00};
      end
      if (wr_prot && i_hwdata[0]) begin
        protect_reg <= 1'b1;
      end
    end
  end

  // buffered copies of override and mask
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      outctl_buf_reg <= ppc_pkg::CH_RESET;
      outval_buf_reg <= ppc_pkg::CH_RESET;
      mask_buf_reg   <= ppc_pkg::CH_RESET;
    end else begin
      if (wr_outctl) outctl_buf_reg <= wd_ch;
      if (wr_outval) outval_buf_reg <= wd_ch;
      if (wr_mask)   mask_buf_reg   <= wd_ch;
    end
  end

  // active copies: direct when unbuffered, on event when buffered
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      outctl_reg <= ppc_pkg::CH_RESET;
      outval_reg <= ppc_pkg::CH_RESET;
      mask_reg   <= ppc_pkg::CH_RESET;
    end else if (!buf_en) begin
      if (wr_outctl) outctl_reg <= wd_ch;
      if (wr_outval) outval_reg <= wd_ch;
      if (wr_mask)   mask_reg   <= wd_ch;
    end else if (comm_take) begin
      outctl_reg <= wr_outctl ? wd_ch : outctl_buf_reg;
      outval_reg <= wr_outval ? wd_ch : outval_buf_reg;
      mask_reg   <= wr_mask   ? wd_ch : mask_buf_reg;
    end
  end

  // compare and polarity per channel
  always_comb begin
    logic [NUM_CH-1:0] inv;
    inv = invert_mask(cfg_reg);
    for (int k = 0; k < NUM_CH; k++) begin
      // high when in pulse for positive, low for negative
      pwm_next[k] = (i_count <= pw_all[k*CNT_WIDTH +: CNT_WIDTH]) ^ inv[k];
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      pwm_reg <= ppc_pkg::CH_RESET;
    end else begin
      pwm_reg <= pwm_next;
    end
  end

  // read mux
  always_comb begin
    rdata_next = 32'h0000_0000;
    case (addr_reg)
      ppc_pkg::CFG_OFFSET:     rdata_next[7:0] = cfg_reg;
      ppc_pkg::OUTCTL_OFFSET:  rdata_next[NUM_CH-1:0] = outctl_buf_reg;
      ppc_pkg::OUTVAL_OFFSET:  rdata_next[NUM_CH-1:0] = outval_buf_reg;
      ppc_pkg::MASK_OFFSET:    rdata_next[NUM_CH-1:0] = mask_buf_reg;
      ppc_pkg::PROTECT_OFFSET: rdata_next[0] = protect_reg;
      ppc_pkg::ACTIVE_OFFSET:  rdata_next[23:0] = {2'b00, mask_reg, 2'b00, outval_reg,
                                                   2'b00, outctl_reg};
      ppc_pkg::STATUS_OFFSET:  rdata_next[NUM_CH-1:0] = pwm_reg;
      default: begin
        if (in_pw_window(addr_reg)) begin
          rdata_next[CNT_WIDTH-1:0] = pw_all[int'(pw_idx)*CNT_WIDTH +: CNT_WIDTH];
        end
      end
    endcase
  end

  // bus outputs: zero wait states, always okay
  assign o_hrdata    = rdata_next;
  assign o_hreadyout = 1'b1;
  assign o_hresp     = 1'b0;

  // channel outputs
  assign o_pwm          = pwm_reg;
  assign o_override_ctl = outctl_reg;
  assign o_override_val = outval_reg;
  assign o_mask         = mask_reg;
endmodule

// ### src/ppc_pkg.sv
/*
  package for the pwm polarity / commutation configuration slice:
  register offsets, field positions, reset values and widths.
  assumes a 32-bit ahb-lite register bus with word-aligned registers.
*/
package ppc_pkg;
  // register byte offsets
  localparam logic [7:0] CFG_OFFSET      = 8'h00; // polarity and commutation config
  localparam logic [7:0] OUTCTL_OFFSET   = 8'h04; // output override control
  localparam logic [7:0] OUTVAL_OFFSET   = 8'h08; // output override value
  localparam logic [7:0] MASK_OFFSET     = 8'h0C; // channel mask bits
  localparam logic [7:0] PROTECT_OFFSET  = 8'h10; // write protect
  localparam logic [7:0] ACTIVE_OFFSET   = 8'h14; // active copies, read only
  localparam logic [7:0] STATUS_OFFSET   = 8'h18; // channel outputs, read only
  localparam logic [7:0] PWVAL_OFFSET    = 8'h1C; // pulse-width values, channel 0..5

  // config register fields
  localparam int CFG_BUF_EN_BIT   = 6; // commutation_buffer_enable
  localparam int CFG_C_LOW_INV    = 5; // pair_c_low_side_invert
  localparam int CFG_WIDTH        = 8;
  localparam logic [7:0] CFG_RESET = 8'h00;

  // channels and counter
  localparam int NUM_CH    = 6;
  localparam int CNT_WIDTH = 15;
  localparam logic [5:0] CH_RESET = 6'h00;
  localparam int C_LOW_CH = 5; // pair_c_bottom_channel
endpackage

// ### src/ppc_pw_mem.sv
/*
  small register memory holding one pulse-width value per channel.
  all words are read out in parallel from flip-flops each cycle.
  assumes a single clock domain with synchronous active-low reset.
*/
`timescale 1ns/1ps
module ppc_pw_mem #(
  parameter int DEPTH = 6,
  parameter int WIDTH = 15
) (
  // clock and reset
  input  wire logic                   i_clk,
  input  wire logic                   i_resetn,
  // write port
  input  wire logic                   i_we,
  input  wire logic [2:0]             i_waddr,
  input  wire logic [WIDTH-1:0]       i_wdata,
  // read port, all words
  output logic      [DEPTH*WIDTH-1:0] o_rdata
);
  logic [WIDTH-1:0] mem_reg [DEPTH];

  // storage; reset clears every word
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      for (int k = 0; k < DEPTH; k++) begin
        mem_reg[k] <= '0;
      end
    end else if (i_we && (int'(i_waddr) < DEPTH)) begin
      mem_reg[i_waddr] <= i_wdata;
    end
  end

  // registered parallel read copy
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_rdata <= '0;
    end else begin
      for (int k = 0; k < DEPTH; k++) begin
        o_rdata[k*WIDTH +: WIDTH] <= mem_reg[k];
      end
    end
  end
endmodule

// ### tb/ppc_cfg_chk.sv
/* port checker for ppc_cfg.
  assumes zero-wait ahb writes and one clock domain. */
`timescale 1ns/1ps
module ppc_cfg_chk #(
  parameter int NUM_CH    = 6,
  parameter int CNT_WIDTH = 15
) (
  // clock and reset
  input wire logic                 i_clk,
  input wire logic                 i_resetn,
  // bus
  input wire logic                 i_hsel,
  input wire logic [31:0]          i_haddr,
  input wire logic [1:0]           i_htrans,
  input wire logic                 i_hwrite,
  input wire logic [31:0]          i_hwdata,
  input wire logic                 i_hready,
  // core side and outputs
  input wire logic [CNT_WIDTH-1:0] i_count,
  input wire logic                 i_comm_event,
  input wire logic [NUM_CH-1:0]    o_pwm,
  input wire logic [NUM_CH-1:0]    o_override_ctl,
  input wire logic [NUM_CH-1:0]    o_override_val,
  input wire logic [NUM_CH-1:0]    o_mask
);
  logic       wr_q, cfg5, ben, prot;
  logic [7:0] adr_q;
  logic [5:0] mbuf;
  // write decodes of the snooped data phase
  wire cfg_wr = wr_q && adr_q == ppc_pkg::CFG_OFFSET && !prot;
  wire mwr    = wr_q && adr_q == ppc_pkg::MASK_OFFSET;
  // shadow of config, protect and mask buffer
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      {wr_q, cfg5, ben, prot, adr_q, mbuf} <= '0;
    end else begin
      wr_q  <= i_hsel && i_hready && i_htrans[1] && i_hwrite;
      adr_q <= i_haddr[7:0];
      if (cfg_wr) {ben, cfg5} <= i_hwdata[6:5];
      if (wr_q && adr_q == ppc_pkg::PROTECT_OFFSET && i_hwdata[0]) prot <= 1'b1;
      if (mwr) mbuf <= i_hwdata[5:0];
    end
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  a_pos_at_zero: assert property (
    $past(i_resetn) && $past(i_count) == '0 |-> &o_pwm[4:0]) else $error("low ch not high");
  a_c_low_pol: assert property (
    $past(i_resetn) && $past(i_count) == '0 |-> o_pwm[5] == !$past(cfg5)) else $error("ch5 pol");
  a_lock_pol: assert property (
    prot && wr_q && adr_q == ppc_pkg::CFG_OFFSET && i_hwdata[5] != cfg5
    |=> ##1 ($past(i_count) != '0 || o_pwm[5] == $past(i_hwdata[5], 2)))
    else $error("locked polarity lost");
  a_mask_now: assert property (
    mwr && !ben |=> o_mask == $past(i_hwdata[5:0])) else $error("mask not direct");
  a_ctl_now: assert property (
    wr_q && adr_q == ppc_pkg::OUTCTL_OFFSET && !ben |=> o_override_ctl == $past(i_hwdata[5:0]))
    else $error("ctl not direct");
  a_mask_held: assert property (
    mwr && ben && !i_comm_event |=> $stable(o_mask)) else $error("mask not held");
  a_evt_load: assert property (
    ben && i_comm_event && !wr_q |=> o_mask == $past(mbuf)) else $error("event load");
  a_evt_ignored: assert property (
    !ben && i_comm_event && !wr_q |=> $stable({o_override_ctl, o_override_val, o_mask}))
    else $error("event not ignored");
  c_evt: cover property (ben && i_comm_event);
  c_prot: cover property (prot && cfg5);
  c_inv: cover property (cfg5 && !o_pwm[5]);
  c_direct: cover property (wr_q && adr_q == ppc_pkg::OUTCTL_OFFSET && !ben);
endmodule
bind ppc_cfg ppc_cfg_chk #(.NUM_CH(NUM_CH), .CNT_WIDTH(CNT_WIDTH)) u_chk (
  .i_clk(i_clk), .i_resetn(i_resetn), .i_hsel(i_hsel), .i_haddr(i_haddr),
  .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hwdata(i_hwdata), .i_hready(i_hready),
  .i_count(i_count), .i_comm_event(i_comm_event), .o_pwm(o_pwm),
  .o_override_ctl(o_override_ctl), .o_override_val(o_override_val), .o_mask(o_mask));

// ### tb/ppc_cfg_tb.sv
/* testbench for ppc_cfg: ahb-lite register tasks and pwm checks.
  assumes zero-wait slave and the ppc_predrv model. */
`timescale 1ns/1ps
module ppc_cfg_tb;
  logic        i_clk = 1'b0, i_resetn = 1'b0, i_hwrite = 1'b0, i_comm_event = 1'b0;
  logic [1:0]  i_htrans = 2'b00;
  logic [31:0] i_haddr = '0, i_hwdata = '0, o_hrdata, rd;
  logic [14:0] i_count = '0;
  logic        o_hreadyout, o_hresp;
  logic [5:0]  o_pwm, o_ctl, o_val, o_mask, gate;
  int          fail_count = 0, comparisons = 0, cyc = 0;
  // clock
  always #5 i_clk = ~i_clk;
  ppc_cfg DUT (.i_clk(i_clk), .i_resetn(i_resetn), .i_hsel(1'b1), .i_haddr(i_haddr),
    .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(3'b010), .i_hwdata(i_hwdata),
    .i_hready(o_hreadyout), .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
    .i_count(i_count), .i_comm_event(i_comm_event), .o_pwm(o_pwm), .o_override_ctl(o_ctl),
    .o_override_val(o_val), .o_mask(o_mask));
  ppc_predrv u_drv (.i_pwm(o_pwm), .o_gate(gate));
  task give_verdict;
    if (fail_count == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // hang guard
  always @(posedge i_clk) begin
    cyc++;
    if (cyc > 3000) begin
      fail_count++;
      give_verdict;
    end
  end
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  // one single ahb transfer
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    i_htrans <= 2'b10;
    i_haddr <= {24'h0, a};
    i_hwrite <= w;
    do @(posedge i_clk); while (o_hreadyout !== 1'b1);
    i_htrans <= 2'b00;
    i_hwdata <= d;
    do @(posedge i_clk); while (o_hreadyout !== 1'b1);
    rd = o_hrdata;
  endtask
  task rchk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk("rdata", e, rd);
    chk("hresp", 32'h0, {31'h0, o_hresp});
  endtask
  task pchk(input logic [14:0] c, input logic [5:0] e);
    i_count <= c;
    repeat (3) @(posedge i_clk);
    chk("pwm", {26'h0, e}, {26'h0, o_pwm});
    chk("gate", {26'h0, e}, {26'h0, gate});
  endtask
  task pulse;
    i_comm_event <= 1'b1;
    @(posedge i_clk);
    i_comm_event <= 1'b0;
    @(posedge i_clk);
  endtask
  task ochk(input logic [17:0] e);
    chk("active", {14'h0, e}, {14'h0, o_mask, o_val, o_ctl});
  endtask
  // main sequence
  initial begin
    repeat (10) @(posedge i_clk);
    i_resetn <= 1'b1;
    @(posedge i_clk);
    rchk(ppc_pkg::CFG_OFFSET, 32'h0);
    rchk(ppc_pkg::MASK_OFFSET, 32'h0);
    for (int k = 0; k < 6; k++) bus(1'b1, ppc_pkg::PWVAL_OFFSET + 8'(4 * k), 32'hA);
    pchk(15'hA, 6'h3F);
    pchk(15'hB, 6'h00);
    bus(1'b1, ppc_pkg::CFG_OFFSET, 32'h20);
    pchk(15'hA, 6'h1F);
    pchk(15'hB, 6'h20);
    bus(1'b1, ppc_pkg::MASK_OFFSET, 32'h15);
    @(posedge i_clk);
    ochk({6'h15, 6'h00, 6'h00});
    pulse;
    ochk({6'h15, 6'h00, 6'h00});
    bus(1'b1, ppc_pkg::CFG_OFFSET, 32'h60);
    bus(1'b1, ppc_pkg::MASK_OFFSET, 32'h2A);
    bus(1'b1, ppc_pkg::OUTCTL_OFFSET, 32'h11);
    bus(1'b1, ppc_pkg::OUTVAL_OFFSET, 32'h07);
    @(posedge i_clk);
    ochk({6'h15, 6'h00, 6'h00});
    rchk(ppc_pkg::MASK_OFFSET, 32'h2A);
    pulse;
    ochk({6'h2A, 6'h07, 6'h11});
    rchk(ppc_pkg::ACTIVE_OFFSET, 32'h002A_0711);
    pchk(15'h0, 6'h1F);
    bus(1'b1, ppc_pkg::PROTECT_OFFSET, 32'h1);
    bus(1'b1, ppc_pkg::CFG_OFFSET, 32'h0);
    rchk(ppc_pkg::CFG_OFFSET, 32'h60);
    pchk(15'h0, 6'h1F);
    rchk(ppc_pkg::PROTECT_OFFSET, 32'h1);
    rchk(ppc_pkg::STATUS_OFFSET, 32'h1F);
    rchk(ppc_pkg::PWVAL_OFFSET + 8'h14, 32'hA);
    rchk(8'h40, 32'h0);
    // mid-run reset must lift the protection
    i_resetn <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_resetn <= 1'b1;
    @(posedge i_clk);
    rchk(ppc_pkg::PROTECT_OFFSET, 32'h0);
    bus(1'b1, ppc_pkg::CFG_OFFSET, 32'h20);
    rchk(ppc_pkg::CFG_OFFSET, 32'h20);
    bus(1'b1, ppc_pkg::OUTCTL_OFFSET, 32'h0C);
    bus(1'b1, ppc_pkg::OUTVAL_OFFSET, 32'h03);
    @(posedge i_clk);
    ochk({6'h00, 6'h03, 6'h0C});
    give_verdict;
  end
endmodule

// ### tb/ppc_predrv.sv
/* external predriver model on the channel outputs.
  assumes pins follow the unit directly, no own timing. */
`timescale 1ns/1ps
module ppc_predrv #(
  parameter logic [5:0] PIN_INV = 6'h00
) (
  // pwm from the unit
  input  wire logic [5:0] i_pwm,
  // gate levels
  output logic      [5:0] o_gate
);
  // stage polarity; left neutral so deadtime is kept
  assign o_gate = i_pwm ^ PIN_INV;
endmodule
